// ==== verilog/fspr_pkg.sv ====
// fspr_pkg: opcodes, field layouts, timing and map of the flash link
package fspr_pkg;

	// flash opcodes
	localparam logic [7:0] OP_WRSR     = 8'h01;
	localparam logic [7:0] OP_PROG     = 8'h02;
	localparam logic [7:0] OP_WRDIS    = 8'h04;
	localparam logic [7:0] OP_RDSR     = 8'h05;
	localparam logic [7:0] OP_WREN     = 8'h06;
	localparam logic [7:0] OP_ERASE4   = 8'h20;
	localparam logic [7:0] OP_ERASE32  = 8'h52;
	localparam logic [7:0] OP_ERASE64  = 8'hD8;
	localparam logic [7:0] OP_SECPROG  = 8'h42;
	localparam logic [7:0] OP_SECERASE = 8'h44;
	localparam logic [7:0] OP_SUSPEND  = 8'h75;
	localparam logic [7:0] OP_RESUME   = 8'h7A;

	// array and frame geometry
	localparam int unsigned ADDR_W    = 21;
	localparam logic [2:0]  BYTES_ADR = 3'h4;
	localparam logic [2:0]  BYTES_SR  = 3'h2;

	// protection byte layout
	localparam int unsigned PB_SIZE   = 0;
	localparam int unsigned PB_SIDE   = 3;
	localparam int unsigned PB_FINE   = 4;
	localparam int unsigned PB_CMP    = 5;
	localparam logic [5:0]  PB_RESET  = 6'h00;
	localparam logic [4:0]  LG_COARSE = 5'h0F;
	localparam logic [4:0]  LG_FINE   = 5'h0B;
	localparam logic [4:0]  LG_FINE64 = 5'h0F;

	// status byte layout
	localparam int unsigned SB_BUSY = 0;
	localparam int unsigned SB_WEL  = 1;
	localparam int unsigned SB_SUS  = 7;

	// timing
	localparam int unsigned CLK_NS        = 10;
	localparam int unsigned RES_LAT_NS    = 1000;
	localparam int unsigned RESUME_CYCLES =
		(RES_LAT_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SCK_HALF      = 4;

	// host register map
	localparam logic [7:0] REG_CMD  = 8'h00;
	localparam logic [7:0] REG_ARG  = 8'h04;
	localparam logic [7:0] REG_RX   = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam logic [7:0] REG_IRQ  = 8'h10;
	localparam logic [7:0] REG_MASK = 8'h14;
	localparam int unsigned CMD_OP  = 0;
	localparam int unsigned CMD_N   = 8;
	localparam int unsigned CMD_RD  = 11;
	localparam logic [2:0]  N_MAX   = 3'h4;

	// engine operation kinds
	typedef enum logic [1:0] {
		FSPR_PROG, FSPR_ERASE, FSPR_SECPROG, FSPR_SECERASE
	} fspr_op_t;

endpackage : fspr_pkg

// ==== verilog/fspr_link_if.sv ====
// fspr_link_if: serial flash pins between controller and device
`timescale 1ns/10ps
interface fspr_link_if;
	logic cs_n;
	logic sck;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic wp_n;

	modport dev_mp (
		input  cs_n, sck, mosi, wp_n,
		output miso, miso_oe
	);
	modport host_mp (
		output cs_n, sck, mosi, wp_n,
		input  miso, miso_oe
	);
endinterface : fspr_link_if

// ==== verilog/fspr_device.sv ====
// fspr_device: flash command end for resume, write latch and protection
`timescale 1ns/10ps
module fspr_device #(
	parameter int unsigned RESUME_CYCLES = fspr_pkg::RESUME_CYCLES
) (
	// system
	input  wire logic                          hclk,
	input  wire logic                          hresetn,
	// flash link
	fspr_link_if.dev_mp                        link,
	// array engine
	output logic                               op_start,
	output fspr_pkg::fspr_op_t                 op_kind,
	output logic [fspr_pkg::ADDR_W-1:0]        op_addr,
	output logic                               op_suspend,
	output logic                               op_resume,
	input  wire logic                          op_done,
	// state seen by the system
	output logic                               busy_flag,
	output logic                               suspended_flag,
	output logic                               write_latch,
	output logic [5:0]                         prot_bits
);

	if (RESUME_CYCLES < 1 || RESUME_CYCLES > 16'hFFFF) begin : g_chk
		$error("fspr_device: RESUME_CYCLES must lie in 1..65535");
	end

	////////////////////////////////////////////////////////////////////
	// pin synchronisers and edges

	logic [3:0] sync1;
	logic [3:0] sync2;
	logic       sck_d;
	logic       cs_d;
	logic       cs_n_s;
	logic       sck_s;
	logic       mosi_s;
	logic       wp_n_s;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= 4'h9;
			sync2 <= 4'h9;
			sck_d <= 1'b0;
			cs_d  <= 1'b1;
		end else begin
			sync1 <= {link.wp_n, link.mosi, link.sck, link.cs_n};
			sync2 <= sync1;
			sck_d <= sck_s;
			cs_d  <= cs_n_s;
		end
	end

	assign cs_n_s = sync2[0];
	assign sck_s  = sync2[1];
	assign mosi_s = sync2[2];
	assign wp_n_s = sync2[3];

	logic sck_rise;
	logic sck_fall;
	logic frame_end;

	assign sck_rise  = !cs_n_s && sck_s && !sck_d;
	assign sck_fall  = !cs_n_s && !sck_s && sck_d;
	assign frame_end = cs_n_s && !cs_d;

	////////////////////////////////////////////////////////////////////
	// frame receiver

	logic [2:0]  bit_cnt;
	logic [2:0]  byte_cnt;
	logic [6:0]  rx_sh;
	logic [7:0]  opcode;
	logic [7:0]  byte1;
	logic [23:0] addr_sh;
	logic [7:0]  full_byte;

	assign full_byte = {rx_sh, mosi_s};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_cnt  <= 3'h0;
			byte_cnt <= 3'h0;
			rx_sh    <= 7'h00;
			opcode   <= 8'h00;
			byte1    <= 8'h00;
			addr_sh  <= 24'h00_0000;
		end else if (cs_n_s) begin
			bit_cnt  <= 3'h0;
			byte_cnt <= 3'h0;
		end else if (sck_rise) begin
			bit_cnt <= bit_cnt + 3'h1;
			rx_sh   <= full_byte[6:0];
			if (bit_cnt == 3'h7) begin
				if (byte_cnt != 3'h7)
					byte_cnt <= byte_cnt + 3'h1;
				if (byte_cnt == 3'h0)
					opcode <= full_byte;
				if (byte_cnt == 3'h1)
					byte1 <= full_byte;
				if (byte_cnt != 3'h0 && byte_cnt < fspr_pkg::BYTES_ADR)
					addr_sh <= {addr_sh[15:0], full_byte};
			end
		end
	end

	logic whole;
	assign whole = frame_end && bit_cnt == 3'h0 && byte_cnt != 3'h0;

	////////////////////////////////////////////////////////////////////
	// protection decode

	function automatic logic is_protected(
		input logic [5:0]                  pb,
		input logic [fspr_pkg::ADDR_W-1:0] a
	);
		logic [2:0]                  size;
		logic [4:0]                  lg;
		logic [fspr_pkg::ADDR_W-1:0] key;
		logic                        hit;
		size = pb[fspr_pkg::PB_SIZE +: 3];
		if (!pb[fspr_pkg::PB_FINE])
			lg = fspr_pkg::LG_COARSE + {2'b00, size};
		else if (size[2])
			lg = fspr_pkg::LG_FINE64;
		else
			lg = fspr_pkg::LG_FINE + {2'b00, size};
		key = pb[fspr_pkg::PB_SIDE] ? a : ~a;
		if (size == 3'h0)
			hit = 1'b0;
		else if (size[2:1] == 2'b11)
			hit = 1'b1;
		else
			hit = (key >> lg) == '0;
		return hit ^ pb[fspr_pkg::PB_CMP];
	endfunction : is_protected

	////////////////////////////////////////////////////////////////////
	// command decision at release

	logic                        prog_run;
	logic                        prog_sus;
	logic                        ers_run;
	logic                        ers_sus;
	logic [15:0]                 res_cnt;
	logic [fspr_pkg::ADDR_W-1:0] tgt;
	logic                        is_erase;
	logic                        prot_hit;
	logic                        do_resume;
	logic                        do_suspend;
	logic                        do_wren;
	logic                        do_wrdis;
	logic                        do_wrsr;
	logic                        do_op;
	fspr_pkg::fspr_op_t          next_kind;

	assign busy_flag      = prog_run || ers_run;
	assign suspended_flag = prog_sus || ers_sus;
	assign tgt            = addr_sh[fspr_pkg::ADDR_W-1:0];
	assign is_erase = opcode == fspr_pkg::OP_ERASE4
		|| opcode == fspr_pkg::OP_ERASE32
		|| opcode == fspr_pkg::OP_ERASE64;
	assign prot_hit = is_protected(prot_bits, tgt);

	assign do_resume = whole && opcode == fspr_pkg::OP_RESUME
		&& suspended_flag && !busy_flag;
	assign do_suspend = whole && opcode == fspr_pkg::OP_SUSPEND
		&& busy_flag && res_cnt == 16'h0_000 && !(prog_run && ers_sus);
	assign do_wren  = whole && opcode == fspr_pkg::OP_WREN;
	assign do_wrdis = whole && opcode == fspr_pkg::OP_WRDIS;
	assign do_wrsr = whole && opcode == fspr_pkg::OP_WRSR
		&& byte_cnt >= fspr_pkg::BYTES_SR && write_latch
		&& !busy_flag && !suspended_flag && wp_n_s;

	always_comb begin
		next_kind = fspr_pkg::FSPR_PROG;
		do_op     = 1'b0;
		if (whole && write_latch && !busy_flag) begin
			if (opcode == fspr_pkg::OP_PROG) begin
				do_op = byte_cnt >= fspr_pkg::BYTES_ADR && !prog_sus
					&& !prot_hit;
			end else if (is_erase) begin
				next_kind = fspr_pkg::FSPR_ERASE;
				do_op = byte_cnt == fspr_pkg::BYTES_ADR
					&& !suspended_flag && !prot_hit;
			end else if (opcode == fspr_pkg::OP_SECPROG) begin
				next_kind = fspr_pkg::FSPR_SECPROG;
				do_op = byte_cnt >= fspr_pkg::BYTES_ADR && !suspended_flag;
			end else if (opcode == fspr_pkg::OP_SECERASE) begin
				next_kind = fspr_pkg::FSPR_SECERASE;
				do_op = byte_cnt == fspr_pkg::BYTES_ADR && !suspended_flag;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// operation state

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prog_run <= 1'b0;
			prog_sus <= 1'b0;
			ers_run  <= 1'b0;
			ers_sus  <= 1'b0;
		end else if (do_resume) begin
			if (prog_sus) begin
				prog_sus <= 1'b0;
				prog_run <= 1'b1;
			end else begin
				ers_sus <= 1'b0;
				ers_run <= 1'b1;
			end
		end else if (do_suspend) begin
			if (prog_run) begin
				prog_run <= 1'b0;
				prog_sus <= 1'b1;
			end else begin
				ers_run <= 1'b0;
				ers_sus <= 1'b1;
			end
		end else if (do_op) begin
			if (next_kind == fspr_pkg::FSPR_ERASE
				|| next_kind == fspr_pkg::FSPR_SECERASE)
				ers_run <= 1'b1;
			else
				prog_run <= 1'b1;
		end else if (op_done) begin
			if (prog_run)
				prog_run <= 1'b0;
			else
				ers_run <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			res_cnt <= 16'h0_000;
		else if (do_resume)
			res_cnt <= 16'(RESUME_CYCLES);
		else if (res_cnt != 16'h0_000)
			res_cnt <= res_cnt - 16'h0_001;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			write_latch <= 1'b0;
		else if (do_wren)
			write_latch <= 1'b1;
		else if (do_wrdis || do_op || do_wrsr)
			write_latch <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			prot_bits <= fspr_pkg::PB_RESET;
		else if (do_wrsr)
			prot_bits <= byte1[5:0];
	end

	// engine strobes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_start   <= 1'b0;
			op_suspend <= 1'b0;
			op_resume  <= 1'b0;
			op_kind    <= fspr_pkg::FSPR_PROG;
			op_addr    <= '0;
		end else begin
			op_start   <= do_op;
			op_suspend <= do_suspend;
			op_resume  <= do_resume;
			if (do_op) begin
				op_kind <= next_kind;
				op_addr <= tgt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// status read output

	logic [7:0] stat_byte;
	logic       rd_active;

	always_comb begin
		stat_byte                   = 8'h00;
		stat_byte[fspr_pkg::SB_BUSY] = busy_flag;
		stat_byte[fspr_pkg::SB_WEL]  = write_latch;
		stat_byte[fspr_pkg::SB_SUS]  = suspended_flag;
	end

	assign rd_active = !cs_n_s && byte_cnt != 3'h0
		&& opcode == fspr_pkg::OP_RDSR;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link.miso    <= 1'b0;
			link.miso_oe <= 1'b0;
		end else begin
			link.miso_oe <= rd_active;
			if (sck_fall && rd_active)
				link.miso <= stat_byte[~bit_cnt];
		end
	end

endmodule : fspr_device

// ==== verilog/fspr_host.sv ====
// fspr_host: register-driven flash command controller on AHB-Lite
`timescale 1ns/10ps
module fspr_host #(
	parameter int unsigned SCK_HALF = fspr_pkg::SCK_HALF
) (
	// system
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// board
	input  wire logic        wp_level,
	output logic             irq,
	// flash link
	fspr_link_if.host_mp     link
);

	if (SCK_HALF < 4 || SCK_HALF > 255) begin : g_chk
		$error("fspr_host: SCK_HALF must lie in 4..255");
	end

	typedef enum logic [2:0] {
		HS_IDLE, HS_LOW, HS_HIGH, HS_TAIL, HS_GAP
	} fspr_hstate_t;

	fspr_hstate_t state;
	logic [7:0]   div;
	logic         tick;
	logic [5:0]   bits;
	logic [39:0]  tx;
	logic [7:0]   rx;
	logic [11:0]  cmd;
	logic [31:0]  arg;
	logic         irq_st;
	logic         irq_mask;
	logic         done_ev;
	logic [1:0]   miso_sync;
	logic         go;

	////////////////////////////////////////////////////////////////////
	// ahb-lite slave

	logic       wr_pend;
	logic [7:0] wr_addr;
	logic       acc;
	logic       rd_irq;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign acc       = hsel && htrans[1] && hready;
	assign rd_irq    = acc && !hwrite && haddr[7:0] == fspr_pkg::REG_IRQ;
	assign go = wr_pend && wr_addr == fspr_pkg::REG_CMD && state == HS_IDLE;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata  <= 32'h0000_0000;
		end else begin
			wr_pend <= acc && hwrite;
			wr_addr <= haddr[7:0];
			if (acc && !hwrite) begin
				if (haddr[7:0] == fspr_pkg::REG_CMD)
					hrdata <= {20'h0_0000, cmd};
				else if (haddr[7:0] == fspr_pkg::REG_ARG)
					hrdata <= arg;
				else if (haddr[7:0] == fspr_pkg::REG_RX)
					hrdata <= {24'h00_0000, rx};
				else if (haddr[7:0] == fspr_pkg::REG_STAT)
					hrdata <= {31'h0000_0000, state != HS_IDLE};
				else if (haddr[7:0] == fspr_pkg::REG_IRQ)
					hrdata <= {31'h0000_0000, irq_st};
				else if (haddr[7:0] == fspr_pkg::REG_MASK)
					hrdata <= {31'h0000_0000, irq_mask};
				else
					hrdata <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd      <= 12'h000;
			arg      <= 32'h0000_0000;
			irq_mask <= 1'b0;
		end else if (wr_pend) begin
			if (go)
				cmd <= hwdata[11:0];
			else if (wr_addr == fspr_pkg::REG_ARG)
				arg <= hwdata;
			else if (wr_addr == fspr_pkg::REG_MASK)
				irq_mask <= hwdata[0];
		end
	end

	// done flag, set wins over read clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_st <= 1'b0;
		else if (done_ev)
			irq_st <= 1'b1;
		else if (rd_irq)
			irq_st <= 1'b0;
	end

	assign irq = irq_st && irq_mask;

	////////////////////////////////////////////////////////////////////
	// link engine

	logic [2:0] nbytes;
	logic [5:0] nbits;

	always_comb begin
		nbytes = hwdata[fspr_pkg::CMD_N +: 3];
		if (nbytes > fspr_pkg::N_MAX)
			nbytes = fspr_pkg::N_MAX;
		nbits = {nbytes, 3'b000} + 6'h08;
		if (hwdata[fspr_pkg::CMD_RD])
			nbits = nbits + 6'h08;
	end

	assign tick = div == 8'(SCK_HALF - 1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			miso_sync <= 2'b00;
		end else begin
			miso_sync <= {miso_sync[0], link.miso};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			link.wp_n <= 1'b1;
		else
			link.wp_n <= wp_level;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state     <= HS_IDLE;
			div       <= 8'h00;
			bits      <= 6'h00;
			tx        <= '0;
			rx        <= 8'h00;
			done_ev   <= 1'b0;
			link.cs_n <= 1'b1;
			link.sck  <= 1'b0;
			link.mosi <= 1'b0;
		end else begin
			done_ev <= 1'b0;
			div     <= (state == HS_IDLE || tick) ? 8'h00 : div + 8'h01;
			case (state)
				HS_IDLE: begin
					if (go) begin
						tx        <= {hwdata[fspr_pkg::CMD_OP +: 8], arg};
						link.mosi <= hwdata[fspr_pkg::CMD_OP + 7];
						bits      <= nbits;
						link.cs_n <= 1'b0;
						state     <= HS_LOW;
					end
				end
				HS_LOW: begin
					if (tick) begin
						link.sck <= 1'b1;
						state    <= HS_HIGH;
					end
				end
				HS_HIGH: begin
					if (tick) begin
						rx        <= {rx[6:0], miso_sync[1]};
						link.sck  <= 1'b0;
						tx        <= {tx[38:0], 1'b0};
						link.mosi <= tx[38];
						bits      <= bits - 6'h01;
						state     <= (bits == 6'h01) ? HS_TAIL : HS_LOW;
					end
				end
				HS_TAIL: begin
					if (tick) begin
						link.cs_n <= 1'b1;
						link.mosi <= 1'b0;
						state     <= HS_GAP;
					end
				end
				HS_GAP: begin
					if (tick) begin
						done_ev <= 1'b1;
						state   <= HS_IDLE;
					end
				end
				default: state <= HS_IDLE;
			endcase
		end
	end

endmodule : fspr_host

// ==== sim/fspr_link_chk.sv ====
// fspr_link_chk: timing and framing checks on the flash link
`timescale 1ns/10ps
module fspr_link_chk #(
	parameter int unsigned SCK_HALF = 4
) (
	// system
	input wire logic	hclk,
	input wire logic	hresetn,
	// flash link
	input wire logic	cs_n,
	input wire logic	sck,
	input wire logic	mosi,
	input wire logic	miso,
	input wire logic	miso_oe,
	input wire logic	wp_n
);
	default clocking dcb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic [7:0]	hi_cnt;
	logic [7:0]	bit_cnt;

	////////////////////////////////////////////////////////////////////////
	// high phase length and bits per frame
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hi_cnt <= 8'h00;
		end else begin
			hi_cnt <= sck ? hi_cnt + 8'h01 : 8'h00;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_cnt <= 8'h00;
		end else if (cs_n) begin
			bit_cnt <= 8'h00;
		end else if ($rose(sck)) begin
			bit_cnt <= bit_cnt + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions and covers
	a_sck_idle_low: assert property (
		cs_n |-> !sck) else $error("link clock runs outside a frame");
	a_sck_high_len: assert property (
		$fell(sck) |-> hi_cnt == SCK_HALF) else $error("clock high too long");
	a_mosi_steady: assert property (
		sck && $past(sck) |-> $stable(mosi)) else $error("data moved high");
	a_whole_bytes: assert property (
		$rose(cs_n) |-> bit_cnt[2:0] == 3'h0 && bit_cnt != 8'h00)
		else $error("frame ended off a byte boundary");
	a_lead_low: assert property (
		$fell(cs_n) |-> (!sck) [*4]) else $error("first bit too early");
	a_frame_gap: assert property (
		$rose(cs_n) |-> cs_n [*4]) else $error("frames too close");
	a_frame_len: assert property (
		$fell(cs_n) |-> ##[1:450] $rose(cs_n)) else $error("frame hangs");
	a_oe_released: assert property (
		cs_n [*8] |-> !miso_oe) else $error("device drives when idle");
	a_oe_in_frame: assert property (
		$rose(miso_oe) |-> !cs_n) else $error("device drives unselected");

	c_status_read: cover property ($rose(miso_oe));
	c_short_frame: cover property ($rose(cs_n) && bit_cnt == 8'h08);
	c_long_frame: cover property ($rose(cs_n) && bit_cnt == 8'h28);
	c_guard_low: cover property ($fell(wp_n));
endmodule : fspr_link_chk

// ==== sim/fspr_tb.sv ====
// fspr_tb: register-level tests across the controller and device pair
`timescale 1ns/10ps
module fspr_tb;
	localparam int unsigned RES_CYC = 200;
	localparam logic [5:0] PT [10] = '{6'h01, 6'h01, 6'h21, 6'h21, 6'h19,
		6'h19, 6'h06, 6'h26, 6'h20, 6'h0D};
	localparam logic [20:0] PA [10] = '{21'h1F_0000, 21'h1E_FFFF,
		21'h1E_FFFF, 21'h1F_0000, 21'h00_0FFF, 21'h00_1000, 21'h0A_BCDE,
		21'h0A_BCDE, 21'h0A_BCDE, 21'h0F_FFFF};
	localparam logic [9:0] PB = 10'b11_0101_0101;

	logic			hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0]		haddr, hwdata, hrdata, r;
	logic [1:0]		htrans;
	logic [2:0]		hsize;
	logic			wp_level, irq, op_start, op_suspend, op_resume;
	fspr_pkg::fspr_op_t	op_kind;
	logic [20:0]		op_addr;
	logic			op_done, busy_flag, suspended_flag, write_latch;
	logic [5:0]		prot_bits;
	int			err_count = 0;
	int			check_count = 0;
	int			cycles = 0;
	int			n_start = 0;
	int			n_susp = 0;
	int			n_res = 0;
	int			ex_start;

	fspr_link_if u_fspr_link_if ();
	fspr_host #(.SCK_HALF(4)) u_fspr_host (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.wp_level(wp_level), .irq(irq), .link(u_fspr_link_if));
	fspr_device #(.RESUME_CYCLES(RES_CYC)) u_fspr_device (.hclk(hclk),
		.hresetn(hresetn), .link(u_fspr_link_if), .op_start(op_start),
		.op_kind(op_kind), .op_addr(op_addr), .op_suspend(op_suspend),
		.op_resume(op_resume), .op_done(op_done), .busy_flag(busy_flag),
		.suspended_flag(suspended_flag), .write_latch(write_latch),
		.prot_bits(prot_bits));
	fspr_link_chk #(.SCK_HALF(4)) u_fspr_link_chk (.hclk(hclk),
		.hresetn(hresetn), .cs_n(u_fspr_link_if.cs_n),
		.sck(u_fspr_link_if.sck), .mosi(u_fspr_link_if.mosi),
		.miso(u_fspr_link_if.miso), .miso_oe(u_fspr_link_if.miso_oe),
		.wp_n(u_fspr_link_if.wp_n));

	////////////////////////////////////////////////////////////////////////
	// clock, inputs at time zero, engine monitor, timeout
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		{hresetn, hsel, hwrite, op_done, htrans} = 6'h00;
		{haddr, hwdata} = 64'h0000_0000_0000_0000;
		hsize = 3'h2;
		wp_level = 1'b1;
	end
	always @(posedge hclk) begin
		cycles++;
		if (op_start === 1'b1) n_start++;
		if (op_suspend === 1'b1) n_susp++;
		if (op_resume === 1'b1) n_res++;
		if (cycles == 20000) begin
			err_count++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic ahb(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : ahb
	task automatic frame(input logic [7:0] op, input logic [2:0] n,
		input logic [31:0] arg, input logic rd);
		logic [31:0] q;
		ahb(1'b1, 32'(fspr_pkg::REG_ARG), arg, q);
		ahb(1'b1, 32'(fspr_pkg::REG_CMD), {20'h0_0000, rd, n, op}, q);
		q = 32'h0000_0001;
		while (q[0] !== 1'b0) ahb(1'b0, 32'(fspr_pkg::REG_STAT), 32'h0, q);
		repeat (4) @(posedge hclk);
		@(negedge hclk);
	endtask : frame
	task automatic wren(input logic [2:0] n);
		frame(fspr_pkg::OP_WREN, n, 32'hA5A5_A5A5, 1'b0);
	endtask : wren
	task automatic prog(input logic [20:0] a);
		frame(fspr_pkg::OP_PROG, 3'h4, {3'h0, a, 8'h5A}, 1'b0);
	endtask : prog
	task automatic wrsr(input logic [5:0] p);
		frame(fspr_pkg::OP_WRSR, 3'h2, {2'b00, p, 24'h00_0000}, 1'b0);
	endtask : wrsr
	task automatic susp;
		frame(fspr_pkg::OP_SUSPEND, 3'h0, 32'h0000_0000, 1'b0);
	endtask : susp
	task automatic resume;
		frame(fspr_pkg::OP_RESUME, 3'h1, 32'hFF00_0000, 1'b0);
	endtask : resume
	task automatic done_pulse;
		@(posedge hclk);
		op_done <= 1'b1;
		@(posedge hclk);
		op_done <= 1'b0;
		repeat (2) @(posedge hclk);
		@(negedge hclk);
	endtask : done_pulse
	task automatic st(input logic [2:0] e);
		chk({29'h0, busy_flag, suspended_flag, write_latch}, {29'h0, e});
	endtask : st
	task automatic test_done;
		if (err_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		chk(32'(prot_bits), 32'h0000_0000);
		st(3'b000);
		wren(3'h1);
		st(3'b001);
		frame(fspr_pkg::OP_WRDIS, 3'h2, 32'h5A5A_0000, 1'b0);
		st(3'b000);
		prog(21'h01_2345);
		chk(n_start, 0);
		wren(3'h0);
		prog(21'h01_2345);
		chk(n_start, 1);
		chk(32'(op_addr), 32'h0001_2345);
		chk(32'(op_kind), 32'(fspr_pkg::FSPR_PROG));
		st(3'b100);
		susp();
		st(3'b010);
		resume();
		st(3'b100);
		chk(n_res, 1);
		susp();
		st(3'b100);
		chk(n_susp, 1);
		repeat (RES_CYC) @(posedge hclk);
		resume();
		chk(n_res, 1);
		done_pulse();
		st(3'b000);
		resume();
		chk(n_res, 1);
		wren(3'h0);
		frame(fspr_pkg::OP_ERASE4, 3'h3, 32'h0100_0000, 1'b0);
		chk(32'(op_kind), 32'(fspr_pkg::FSPR_ERASE));
		susp();
		st(3'b010);
		wren(3'h0);
		prog(21'h00_1000);
		chk(n_start, 3);
		st(3'b110);
		done_pulse();
		st(3'b010);
		resume();
		chk(n_res, 2);
		st(3'b100);
		done_pulse();
		ex_start = 3;
		for (int i = 0; i < 10; i++) begin
			wren(3'h0);
			wrsr(PT[i]);
			chk(32'(prot_bits), 32'(PT[i]));
			wren(3'h0);
			prog(PA[i]);
			if (PB[i] == 1'b0) ex_start++;
			chk(n_start, ex_start);
			if (PB[i] == 1'b0) done_pulse();
		end
		@(posedge hclk);
		wp_level <= 1'b0;
		wren(3'h0);
		wrsr(6'h00);
		chk(32'(prot_bits), 32'h0000_000D);
		wren(3'h0);
		prog(21'h0F_FFFF);
		chk(n_start, ex_start);
		@(posedge hclk);
		wp_level <= 1'b1;
		wren(3'h0);
		wrsr(6'h00);
		chk(32'(prot_bits), 32'h0000_0000);
		wren(3'h0);
		frame(fspr_pkg::OP_SECERASE, 3'h3, 32'h0001_0000, 1'b0);
		chk(32'(op_kind), 32'(fspr_pkg::FSPR_SECERASE));
		done_pulse();
		wren(3'h0);
		frame(fspr_pkg::OP_SECPROG, 3'h4, 32'h0001_0000, 1'b0);
		chk(32'(op_kind), 32'(fspr_pkg::FSPR_SECPROG));
		done_pulse();
		ahb(1'b1, 32'(fspr_pkg::REG_MASK), 32'h0000_0001, r);
		ahb(1'b0, 32'(fspr_pkg::REG_IRQ), 32'h0000_0000, r);
		@(negedge hclk);
		chk(32'(irq), 32'h0000_0000);
		wren(3'h0);
		frame(fspr_pkg::OP_RDSR, 3'h0, 32'h0000_0000, 1'b1);
		chk(32'(irq), 32'h0000_0001);
		ahb(1'b0, 32'(fspr_pkg::REG_RX), 32'h0000_0000, r);
		chk(r & 32'h0000_0083, 32'h0000_0002);
		ahb(1'b0, 32'(fspr_pkg::REG_IRQ), 32'h0000_0000, r);
		chk(32'(r[0]), 32'h0000_0001);
		@(negedge hclk);
		chk(32'(irq), 32'h0000_0000);
		ahb(1'b0, 32'h0000_0020, 32'h0000_0000, r);
		chk(r, 32'h0000_0000);
		chk(32'(hresp), 32'h0000_0000);
		test_done();
	end
endmodule : fspr_tb
